// ==== srfr_fifo.sv ====
// Frame descriptor FIFO with a registered output slot.
`timescale 1ns/10ps
module srfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  logic        clk,
  input  logic        rst_n,
  srfr_fifo_if.fifo   bus
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        slot_v;
    logic [WIDTH-1:0]            slot_d;
  } srfr_fifo_state_s;

  srfr_fifo_state_s st_reg;
  srfr_fifo_state_s st_next;
  logic             push;
  logic             pop_mem;

  assign bus.wr_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign bus.rd_valid = st_reg.slot_v;
  assign bus.rd_data  = st_reg.slot_d;

  always_comb begin
    st_next = st_reg;
    push    = bus.wr_valid & bus.wr_ready;
    // The slot refills in the same cycle it is drained, so a stalled reader keeps the FIFO filling.
    pop_mem = (!st_reg.slot_v | bus.rd_ready) & (st_reg.count != '0);
    if (pop_mem) begin
      st_next.slot_d = st_reg.mem[st_reg.rptr];
      st_next.slot_v = 1'b1;
      st_next.rptr   = st_reg.rptr + 1'b1;
    end else if (bus.rd_ready) begin
      st_next.slot_v = 1'b0;
    end
    if (push) begin
      st_next.mem[st_reg.wptr] = bus.wr_data;
      st_next.wptr             = st_reg.wptr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop_mem);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : srfr_fifo

// ==== srfr_fifo_if.sv ====
// Valid/ready carrier between the relay and its frame FIFO.
`timescale 1ns/10ps
interface srfr_fifo_if #(
  parameter int WIDTH = 8
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo (input wr_valid, input wr_data, input rd_ready,
                output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
endinterface : srfr_fifo_if

// ==== srfr_mac_sink.sv ====
// Model of the outbound MAC entities that accept relayed frames.
`timescale 1ns/10ps
module srfr_mac_sink (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic        tx_valid,
  input  wire logic [85:0] frame,
  output logic             tx_ready
);
  logic        phase;
  logic [85:0] q[$];

  // A slow MAC accepts only every other cycle, so the relay must hold its frame meanwhile.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase    <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      phase    <= ~phase;
      tx_ready <= !stall && (!slow || phase);
      if (tx_valid && tx_ready) q.push_back(frame);
    end
  end
endmodule : srfr_mac_sink

// ==== srfr_params.svh ====
// Constant definitions for the source-route frame relay core.
`ifndef SRFR_PARAMS_SVH
`define SRFR_PARAMS_SVH

// Register byte offsets on the bus.
`define SRFR_OFF_CTRL      8'h00
`define SRFR_OFF_PORT0     8'h04
`define SRFR_OFF_PORT1     8'h08
`define SRFR_OFF_DELAY     8'h0c
`define SRFR_OFF_COUNT     8'h10
`define SRFR_ADDR_BITS     7:0

// Control register fields.
`define SRFR_CTRL_EN       0
`define SRFR_CTRL_FWD      2:1
`define SRFR_CTRL_BLF      6:4
`define SRFR_CTRL_PATH     11:8

// Port configuration word and delay word fields.
`define SRFR_PCFG_FIELD    19:0
`define SRFR_DELAY_FIELD   15:0

// Reset values.
`define SRFR_RST_EN        1'b1
`define SRFR_RST_FWD       2'h3
`define SRFR_RST_BLF       3'h7
`define SRFR_RST_PATH      4'h1
`define SRFR_RST_PORT0     20'he_7001
`define SRFR_RST_PORT1     20'he_7002
`define SRFR_RST_DELAY     16'h0400

// Route control word layout.
`define SRFR_RC_TYPE       15:13
`define SRFR_RC_LTH        12:8
`define SRFR_RC_SIZE       6:4
`define SRFR_RC_EXT        3:1
`define SRFR_TYPE_EXPLORER 2
`define SRFR_TYPE_TREE     1
`define SRFR_LTH_EMPTY     6'h02
`define SRFR_LTH_MAX       6'h1e
`define SRFR_LTH_ONE_RD    6'h02
`define SRFR_LTH_TWO_RD    6'h04
`define SRFR_EXT_CLEAR     3'h0
`define SRFR_LAST_PATH     4'h0

// Largest service data unit, in octets, per 3-bit size code.
`define SRFR_LF_SIZE0      16'h0204
`define SRFR_LF_SIZE1      16'h05be
`define SRFR_LF_SIZE2      16'h0804
`define SRFR_LF_SIZE3      16'h112f
`define SRFR_LF_SIZE4      16'h1fc2
`define SRFR_LF_SIZE5      16'h2c8f
`define SRFR_LF_SIZE6      16'h4555
`define SRFR_LF_SIZE7      16'hffff

`define SRFR_FIFO_DEPTH    16

`endif

// ==== srfr_pkg.sv ====
// Types shared by the source-route frame relay core.
package srfr_pkg;

  typedef struct packed {
    logic [3:0]  rd_limit;
    logic        mac_type;
    logic [2:0]  lf_code;
    logic [11:0] segment_identifier;
  } srfr_port_cfg_s;

  typedef struct packed {
    logic        out_port;
    logic        transparent;
    logic        learn_sa;
    logic        fcs_regen;
    logic [15:0] route_ctrl;
    logic [15:0] last_rd;
    logic [15:0] new_rd0;
    logic [15:0] new_rd1;
    logic [1:0]  add_count;
    logic [15:0] sdu_len;
    logic [15:0] stamp;
  } srfr_entry_s;

  typedef struct packed {
    logic                 ctrl_en;
    logic [1:0]           fwd_state;
    logic [2:0]           bridge_lf;
    logic [3:0]           parallel_path_number;
    srfr_port_cfg_s [1:0] port;
    logic [15:0]          max_delay;
    logic [7:0]           cnt_err;
    logic [7:0]           cnt_size;
    logic [7:0]           cnt_delay;
    logic [7:0]           cnt_route;
    logic [15:0]          now;
    logic                 ap_valid;
    logic                 ap_write;
    logic [7:0]           ap_addr;
    logic [31:0]          rdata;
    logic                 out_valid;
    srfr_entry_s          out;
  } srfr_state_s;

endpackage : srfr_pkg

// ==== srfr_relay.sv ====
// Source-route frame relay core between two MAC ports, with an AHB-Lite register slave.
// Overview of operation
// - Frames leave in arrival order through one shared FIFO.
// - Frames without route information are flagged for the transparent path only.
// - Frames with route information are handled by the route field logic.
// - Source address learning is requested only for frames without route information.
// - Same MAC type on both ports: specifically routed frames keep content and FCS.
// - Different MAC types: a routed frame is adapted and its FCS regenerated.
// - Any change to the route field forces FCS regeneration.
// - Explorers record inbound segment, path number and outbound segment.
// - Explorer largest-frame code is lowered only when the new value is smaller.
// - Routed frames larger than the outbound port can carry are discarded.
// - Frames that waited in the FIFO longer than the configured transit delay are discarded.
// - Frames the MAC marks as errored are discarded and never forwarded.
// - Each port holds segment, largest unit size, port type and descriptor limit.
// - Route type 0XX is specific, 10X all-routes, 11X tree explorer; X kept.
// - Tree explorers pass only when both ports are in the forwarding state.
// - A descriptor is 12-bit segment plus 4-bit path; the last path is zero.
// - Explorer largest-frame code is the minimum of frame, bridge and both ports.
`timescale 1ns/10ps
`include "srfr_params.svh"
module srfr_relay (
  input  logic                    hclk,
  input  logic                    hresetn,
  // Register bus.
  input  logic                    hsel,
  input  logic [31:0]             haddr,
  input  logic [1:0]              htrans,
  input  logic                    hwrite,
  input  logic [2:0]              hsize,
  input  logic [31:0]             hwdata,
  input  logic                    hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Frames from the inbound MAC.
  input  logic                    rx_valid,
  output logic                    rx_ready,
  input  logic                    rx_port,
  input  logic                    rx_route_info_present_bit,
  input  logic                    rx_err,
  input  logic [15:0]             rx_route_ctrl,
  input  logic [15:0]             rx_last_rd,
  input  logic [15:0]             rx_sdu_len,
  // Frames to the outbound MAC.
  output logic                    tx_valid,
  input  logic                    tx_ready,
  output logic                    tx_port,
  output logic                    tx_transparent,
  output logic                    tx_learn_sa,
  output logic                    tx_fcs_regen,
  output logic [15:0]             tx_route_ctrl,
  output logic [15:0]             tx_last_rd,
  output logic [15:0]             tx_new_rd0,
  output logic [15:0]             tx_new_rd1,
  output logic [1:0]              tx_add_count,
  output logic [15:0]             tx_sdu_len
);
  import srfr_pkg::*;

  // All state outside the FIFO is one struct, built below and held by one flop stage.
  srfr_state_s st_reg;
  srfr_state_s st_next;

  srfr_entry_s ent;
  srfr_entry_s head;

  // Configuration of the inbound and the outbound port.
  srfr_port_cfg_s cfg_in;
  srfr_port_cfg_s cfg_out;

  // Received route control fields and their updated values.
  logic [2:0]  route_type_field;
  logic [2:0]  largest_frame_bits;
  logic [2:0]  lf_min;
  logic [5:0]  lth_new;
  logic [15:0] age;

  // Discard reasons, in order of precedence.
  logic        drop_err;
  logic        drop_size;
  logic        drop_route;
  logic        drop;

  // The frame input handshake completes this cycle.
  logic        rx_take;

  // Kept frames wait here in arrival order; frames discarded at ingress never enter.
  srfr_fifo_if #(.WIDTH($bits(srfr_entry_s))) fifo_bus ();

  srfr_fifo #(
    .WIDTH ($bits(srfr_entry_s)),
    .DEPTH (`SRFR_FIFO_DEPTH)
  ) u_fifo (
    .clk   (hclk),
    .rst_n (hresetn),
    .bus   (fifo_bus.fifo)
  );

  // Code seven is the largest size and so never limits a frame here.
  function automatic logic [15:0] lf_bytes(input logic [2:0] code);
    case (code)
      3'h0:    lf_bytes = `SRFR_LF_SIZE0;
      3'h1:    lf_bytes = `SRFR_LF_SIZE1;
      3'h2:    lf_bytes = `SRFR_LF_SIZE2;
      3'h3:    lf_bytes = `SRFR_LF_SIZE3;
      3'h4:    lf_bytes = `SRFR_LF_SIZE4;
      3'h5:    lf_bytes = `SRFR_LF_SIZE5;
      3'h6:    lf_bytes = `SRFR_LF_SIZE6;
      default: lf_bytes = `SRFR_LF_SIZE7;
    endcase
  endfunction : lf_bytes

  // Size codes grow with frame size, so the smaller code is the tighter limit.
  function automatic logic [2:0] min_code(input logic [2:0] a, input logic [2:0] b);
    min_code = (a < b) ? a : b;
  endfunction : min_code

  // The slave never inserts wait states and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rdata;

  // Frame outputs come straight from the output register.
  assign tx_valid       = st_reg.out_valid;
  assign tx_port        = st_reg.out.out_port;
  assign tx_transparent = st_reg.out.transparent;
  assign tx_learn_sa    = st_reg.out.learn_sa;
  assign tx_fcs_regen   = st_reg.out.fcs_regen;
  assign tx_route_ctrl  = st_reg.out.route_ctrl;
  assign tx_last_rd     = st_reg.out.last_rd;
  assign tx_new_rd0     = st_reg.out.new_rd0;
  assign tx_new_rd1     = st_reg.out.new_rd1;
  assign tx_add_count   = st_reg.out.add_count;
  assign tx_sdu_len     = st_reg.out.sdu_len;

  always_comb begin
    st_next            = st_reg;
    // Ages wrap at 16 bits, so no transit limit beyond that can be set.
    st_next.now        = st_reg.now + 16'h0001;
    // With two ports the outbound port is always the other one.
    cfg_in             = st_reg.port[rx_port];
    cfg_out            = st_reg.port[~rx_port];
    route_type_field   = rx_route_ctrl[`SRFR_RC_TYPE];
    largest_frame_bits = rx_route_ctrl[`SRFR_RC_SIZE];
    lth_new            = {1'b0, rx_route_ctrl[`SRFR_RC_LTH]};
    lf_min             = largest_frame_bits;
    drop_err           = rx_err;
    drop_size          = 1'b0;
    drop_route         = 1'b0;

    // By default the frame leaves unchanged by the other port.
    ent                = '0;
    ent.out_port       = ~rx_port;
    ent.route_ctrl     = rx_route_ctrl;
    ent.last_rd        = rx_last_rd;
    ent.sdu_len        = rx_sdu_len;
    ent.stamp          = st_reg.now;

    // Ingress classification.
    // Only frames for the transparent path may have their source learned.
    if (!rx_route_info_present_bit) begin
      ent.transparent = 1'b1;
      ent.learn_sa    = 1'b1;
    end else begin
      // Specifically routed frames pass untouched when the MAC types agree.
      ent.fcs_regen = (cfg_in.mac_type != cfg_out.mac_type);
      // Transparent frames skip the size check; that path is not modelled here.
      drop_size     = (rx_sdu_len > lf_bytes(cfg_out.lf_code));
      if (route_type_field[`SRFR_TYPE_EXPLORER]) begin
        // Explorers always gain a descriptor, so the FCS is always rebuilt.
        ent.fcs_regen = 1'b1;
        // The new code is the least of the frame, the bridge and both ports.
        lf_min = min_code(min_code(largest_frame_bits, st_reg.bridge_lf),
                          min_code(cfg_in.lf_code, cfg_out.lf_code));
        // Extension bits qualify the old base code, so they are cleared with it.
        if (lf_min < largest_frame_bits) begin
          ent.route_ctrl[`SRFR_RC_SIZE] = lf_min;
          ent.route_ctrl[`SRFR_RC_EXT] = `SRFR_EXT_CLEAR;
        end
        // An empty field gets both descriptors; otherwise only the outbound one.
        if (lth_new == `SRFR_LTH_EMPTY) begin
          ent.new_rd0   = {cfg_in.segment_identifier, st_reg.parallel_path_number};
          ent.new_rd1   = {cfg_out.segment_identifier, `SRFR_LAST_PATH};
          ent.add_count = 2'h2;
          lth_new       = lth_new + `SRFR_LTH_TWO_RD;
        end else begin
          // The old final descriptor carried a zero path; our path number replaces it.
          ent.last_rd   = {rx_last_rd[15:4], st_reg.parallel_path_number};
          ent.new_rd0   = {cfg_out.segment_identifier, `SRFR_LAST_PATH};
          ent.add_count = 2'h1;
          lth_new       = lth_new + `SRFR_LTH_ONE_RD;
        end
        ent.route_ctrl[`SRFR_RC_LTH] = lth_new[4:0];

        // Tree explorers follow the spanning tree, so both ports must forward.
        if (route_type_field[`SRFR_TYPE_TREE] && (st_reg.fwd_state != 2'b11)) begin
          drop_route = 1'b1;
        end
        // A field beyond 30 octets cannot be carried, so such a frame is lost.
        if ((lth_new > `SRFR_LTH_MAX) ||
            (((lth_new - `SRFR_LTH_EMPTY) >> 1) > {2'b00, cfg_out.rd_limit})) begin
          drop_route = 1'b1;
        end
      end
    end

    drop                 = drop_err | drop_size | drop_route;
    // Discarded frames are taken at once; kept frames wait for FIFO room.
    rx_ready             = st_reg.ctrl_en & (drop | fifo_bus.wr_ready);
    rx_take              = rx_valid & rx_ready;
    fifo_bus.wr_valid    = rx_valid & st_reg.ctrl_en & !drop;
    fifo_bus.wr_data     = ent;

    // Each discarded frame is counted once, under its first reason.
    if (rx_take && drop_err) begin
      st_next.cnt_err = st_reg.cnt_err + 8'h01;
    end else if (rx_take && drop_size) begin
      st_next.cnt_size = st_reg.cnt_size + 8'h01;
    end else if (rx_take && drop_route) begin
      st_next.cnt_route = st_reg.cnt_route + 8'h01;
    end

    // Egress: the head entry's age is checked as it leaves the FIFO.
    // A frame already in the output register is not aged again while stalled.
    fifo_bus.rd_ready = !st_reg.out_valid | tx_ready;
    head              = fifo_bus.rd_data;
    age               = st_reg.now - head.stamp;
    if (st_reg.out_valid && tx_ready) begin
      st_next.out_valid = 1'b0;
    end
    if (fifo_bus.rd_valid && fifo_bus.rd_ready) begin
      if (age > st_reg.max_delay) begin
        st_next.cnt_delay = st_reg.cnt_delay + 8'h01;
      end else begin
        st_next.out       = head;
        st_next.out_valid = 1'b1;
      end
    end

    // Register writes land in the data phase.
    // Writes to unmapped offsets or to the counters are ignored.
    if (st_reg.ap_valid && st_reg.ap_write) begin
      case (st_reg.ap_addr)
        `SRFR_OFF_CTRL: begin
          // One path number serves the single port pair of this bridge.
          st_next.ctrl_en              = hwdata[`SRFR_CTRL_EN];
          st_next.fwd_state            = hwdata[`SRFR_CTRL_FWD];
          st_next.bridge_lf            = hwdata[`SRFR_CTRL_BLF];
          st_next.parallel_path_number = hwdata[`SRFR_CTRL_PATH];
        end
        // Port words hold segment, size code, MAC type and descriptor limit.
        `SRFR_OFF_PORT0: st_next.port[0]   = hwdata[`SRFR_PCFG_FIELD];
        `SRFR_OFF_PORT1: st_next.port[1]   = hwdata[`SRFR_PCFG_FIELD];
        `SRFR_OFF_DELAY: st_next.max_delay = hwdata[`SRFR_DELAY_FIELD];
        default: begin
        end
      endcase
    end

    // The address phase is kept one cycle so a write can meet its data.
    st_next.ap_valid = hsel & htrans[1] & hready;
    st_next.ap_write = hwrite;
    st_next.ap_addr  = haddr[`SRFR_ADDR_BITS];

    // Read data is sampled from the next state so a read right after a write sees the new value.
    st_next.rdata = 32'h0000_0000;
    if (st_next.ap_valid && !hwrite) begin
      case (haddr[`SRFR_ADDR_BITS])
        `SRFR_OFF_CTRL: begin
          st_next.rdata[`SRFR_CTRL_EN]   = st_next.ctrl_en;
          st_next.rdata[`SRFR_CTRL_FWD]  = st_next.fwd_state;
          st_next.rdata[`SRFR_CTRL_BLF]  = st_next.bridge_lf;
          st_next.rdata[`SRFR_CTRL_PATH] = st_next.parallel_path_number;
        end
        `SRFR_OFF_PORT0: st_next.rdata[`SRFR_PCFG_FIELD]  = st_next.port[0];
        `SRFR_OFF_PORT1: st_next.rdata[`SRFR_PCFG_FIELD]  = st_next.port[1];
        `SRFR_OFF_DELAY: st_next.rdata[`SRFR_DELAY_FIELD] = st_next.max_delay;
        // All four counters share one word, the error count lowest.
        `SRFR_OFF_COUNT: st_next.rdata = {st_next.cnt_route, st_next.cnt_delay,
                                          st_next.cnt_size, st_next.cnt_err};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Configuration resets to working values, so frames relay before any write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg                      <= '0;
      st_reg.ctrl_en              <= `SRFR_RST_EN;
      st_reg.fwd_state            <= `SRFR_RST_FWD;
      st_reg.bridge_lf            <= `SRFR_RST_BLF;
      st_reg.parallel_path_number <= `SRFR_RST_PATH;
      st_reg.port[0]              <= `SRFR_RST_PORT0;
      st_reg.port[1]              <= `SRFR_RST_PORT1;
      st_reg.max_delay            <= `SRFR_RST_DELAY;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : srfr_relay

// ==== srfr_relay_assertions.sv ====
// Concurrent checks on the ports of the source-route frame relay core.
`timescale 1ns/10ps
module srfr_relay_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        rx_port,
  input wire logic        rx_route_info_present_bit,
  input wire logic        rx_err,
  input wire logic [15:0] rx_route_ctrl,
  input wire logic [15:0] rx_last_rd,
  input wire logic [15:0] rx_sdu_len,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_port,
  input wire logic        tx_transparent,
  input wire logic        tx_learn_sa,
  input wire logic        tx_fcs_regen,
  input wire logic [15:0] tx_route_ctrl,
  input wire logic [15:0] tx_last_rd,
  input wire logic [15:0] tx_new_rd0,
  input wire logic [15:0] tx_new_rd1,
  input wire logic [1:0]  tx_add_count,
  input wire logic [15:0] tx_sdu_len
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_stalled;
    tx_valid && !tx_ready;
  endsequence
  // A frame that changes while stalled would reach the MAC torn between two descriptors.
  sequence s_held;
    tx_valid && $stable({tx_port, tx_transparent, tx_learn_sa, tx_fcs_regen, tx_route_ctrl,
                         tx_last_rd, tx_new_rd0, tx_new_rd1, tx_add_count, tx_sdu_len});
  endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  chk_rdata_idle: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");
  chk_tx_held: assert property (s_stalled |=> s_held)
    else $error("output frame changed while stalled");
  chk_learn_transp: assert property (tx_valid && tx_learn_sa |-> tx_transparent)
    else $error("learning on a routed frame");
  chk_transp_plain: assert property (tx_valid && tx_transparent |-> tx_add_count == 2'h0)
    else $error("transparent frame got descriptors");
  chk_explorer_adds: assert property (tx_valid && !tx_transparent && tx_route_ctrl[15] |->
                                      tx_add_count inside {2'h1, 2'h2} && tx_fcs_regen)
    else $error("explorer without descriptor or checksum refresh");
  chk_srf_untouched: assert property (tx_valid && !tx_transparent && !tx_route_ctrl[15] |->
                                      tx_add_count == 2'h0)
    else $error("specific frame got descriptors");
  chk_last_path: assert property (tx_valid && tx_add_count != 2'h0 |->
                                  (tx_add_count == 2'h1 ? tx_new_rd0[3:0] : tx_new_rd1[3:0]) == 4'h0)
    else $error("final path number not zero");
  chk_empty_grows: assert property (tx_valid && tx_add_count == 2'h2 |-> tx_route_ctrl[12:8] == 5'h06)
    else $error("length wrong after two descriptors");
endmodule : srfr_relay_assertions

// ==== tb_source_route_frame_relay.sv ====
// Self-checking bench for the source-route frame relay core.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_source_route_frame_relay;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, tx_add_count;
  logic [2:0]  hsize;
  logic        rx_valid, rx_ready, rx_port, rx_route_info_present_bit, rx_err;
  logic [15:0] rx_route_ctrl, rx_last_rd, rx_sdu_len;
  logic        tx_valid, tx_ready, tx_port, tx_transparent, tx_learn_sa, tx_fcs_regen;
  logic [15:0] tx_route_ctrl, tx_last_rd, tx_new_rd0, tx_new_rd1, tx_sdu_len;
  logic        stall, slow, tk;
  int          bad_count = 0, n_tests = 0, cycles = 0, n, i;
  logic [31:0] rst_vals [6] = '{32'h0000_0177, 32'h000e_7001, 32'h000e_7002, 32'h0000_0400,
                                32'h0000_0000, 32'h0000_0000};

  assign hready = hreadyout;
  srfr_relay DUT (.*);
  srfr_mac_sink mac (.hclk(hclk), .hresetn(hresetn), .stall(stall), .slow(slow), .tx_valid(tx_valid),
    .frame({tx_port, tx_transparent, tx_learn_sa, tx_fcs_regen, tx_route_ctrl, tx_last_rd, tx_new_rd0,
            tx_new_rd1, tx_add_count, tx_sdu_len}), .tx_ready(tx_ready));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (!hready);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (!hready);
    rd = hrdata;
  endtask : ahb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask : rchk

  // The offer stays up after acceptance so that frames can follow back to back.
  task automatic send(input logic p, route_info_present_bit, err, input logic [15:0] rc, last, len);
    rx_valid                  <= 1'b1;
    rx_port                   <= p;
    rx_route_info_present_bit <= route_info_present_bit;
    rx_err                    <= err;
    rx_route_ctrl             <= rc;
    rx_last_rd                <= last;
    rx_sdu_len                <= len;
    tk = 1'b0;
    for (int k = 0; k < 50 && !tk; k++) begin
      @(posedge hclk);
      tk = rx_ready;
    end
  endtask : send

  task automatic idle;
    rx_valid <= 1'b0;
    @(posedge hclk);
  endtask : idle

  // Descriptor fields that the frame does not carry are masked out of the comparison.
  task automatic get(input logic [3:0] fl, input logic [15:0] rc, last, r0, r1, input logic [1:0] a,
                     input logic [15:0] s);
    logic [85:0] e, g, m;
    e = {fl, rc, last, r0, r1, a, s};
    m = '1;
    for (int k = 0; k < 200 && mac.q.size() == 0; k++) @(posedge hclk);
    if (a != 2'h2) m[33:18] = 16'h0000;
    if (a == 2'h0) m[49:34] = 16'h0000;
    if (a == 2'h2) m[65:50] = 16'h0000;
    g = (mac.q.size() != 0) ? mac.q.pop_front() : ~e;
    `CHK(g & m, e & m)
  endtask : get

  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, stall, slow} = '0;
    {rx_valid, rx_port, rx_route_info_present_bit, rx_err, rx_route_ctrl, rx_last_rd, rx_sdu_len} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 6; i++) rchk(8'(4 * i), rst_vals[i]);
    ahb(1'b1, 8'h14, 32'hffff_ffff);
    rchk(8'h14, 32'h0000_0000);
    send(1'b0, 1'b0, 1'b0, 16'h1234, 16'habcd, 16'h0100);
    send(1'b0, 1'b1, 1'b0, 16'h0430, 16'h0012, 16'h0200);
    send(1'b0, 1'b1, 1'b0, 16'ha275, 16'h0000, 16'h0100);
    idle();
    get(4'b1110, 16'h1234, 16'habcd, 16'h0000, 16'h0000, 2'h0, 16'h0100);
    get(4'b1000, 16'h0430, 16'h0012, 16'h0000, 16'h0000, 2'h0, 16'h0200);
    get(4'b1001, 16'ha675, 16'h0000, 16'h0011, 16'h0020, 2'h2, 16'h0100);
    stall <= 1'b1;
    n = 0;
    for (i = 0; i < 20; i++) begin
      send(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'(i));
      if (!tk) break;
      n++;
    end
    idle();
    `CHK(n, 18)
    slow  <= 1'b1;
    stall <= 1'b0;
    for (i = 0; i < 18; i++) get(4'b1110, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 2'h0, 16'(i));
    slow <= 1'b0;
    ahb(1'b1, 8'h0c, 32'h0000_0000);
    stall <= 1'b1;
    send(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0055);
    idle();
    repeat (10) @(posedge hclk);
    stall <= 1'b0;
    repeat (10) @(posedge hclk);
    `CHK(mac.q.size() == 0, 1'b1)
    ahb(1'b1, 8'h0c, 32'h0000_0400);
    ahb(1'b1, 8'h08, 32'h000e_3002);
    send(1'b0, 1'b1, 1'b0, 16'h847a, 16'h0010, 16'h0100);
    send(1'b0, 1'b1, 1'b0, 16'h0430, 16'h0000, 16'h1130);
    send(1'b0, 1'b1, 1'b0, 16'h0430, 16'h0000, 16'h112f);
    send(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0040);
    idle();
    get(4'b1001, 16'h8630, 16'h0011, 16'h0020, 16'h0000, 2'h1, 16'h0100);
    get(4'b1000, 16'h0430, 16'h0000, 16'h0000, 16'h0000, 2'h0, 16'h112f);
    ahb(1'b1, 8'h00, 32'h0000_0173);
    send(1'b0, 1'b1, 1'b0, 16'hc230, 16'h0000, 16'h0111);
    idle();
    ahb(1'b1, 8'h00, 32'h0000_0277);
    send(1'b0, 1'b1, 1'b0, 16'hc230, 16'h0000, 16'h0100);
    idle();
    get(4'b1001, 16'hc630, 16'h0000, 16'h0012, 16'h0020, 2'h2, 16'h0100);
    ahb(1'b1, 8'h08, 32'h000e_b002);
    send(1'b1, 1'b1, 1'b0, 16'h0430, 16'h0012, 16'h0200);
    idle();
    get(4'b0001, 16'h0430, 16'h0012, 16'h0000, 16'h0000, 2'h0, 16'h0200);
    `CHK(mac.q.size() == 0, 1'b1)
    rchk(8'h10, 32'h0101_0101);
    ahb(1'b1, 8'h10, 32'hffff_ffff);
    rchk(8'h10, 32'h0101_0101);
    final_report();
  end
endmodule : tb_source_route_frame_relay

bind srfr_relay srfr_relay_assertions u_chk (.*);
